/* File: design/nal_regs.svh */
// constants for the nibble arithmetic and logic datapath
`ifndef NAL_REGS_SVH
`define NAL_REGS_SVH
`define NAL_NIB_W      4
`define NAL_ADDR_W     9
`define NAL_WREG_W     4
`define NAL_WREG_BASE  9'h000
`define NAL_NIB_ZERO   4'h0
`define NAL_PTR_RST    9'h000
`define NAL_PTR_STEP   9'h001
`define NAL_CARRY_RST  1'b0
`endif

/* File: design/nal_pkg.sv */
// types for the nibble arithmetic and logic datapath
package nal_pkg;
    // operation codes issued by the decoder
    typedef enum logic [3:0] {
        NAL_OP_NONE,
        NAL_OP_ADD_KEEP_CARRY,
        NAL_OP_CONJUNCTION,
        NAL_OP_EXCL_DISJUNCTION,
        NAL_OP_DISJUNCTION,
        NAL_OP_IMM_ADD_WITH_CARRY,
        NAL_OP_IMM_SUBTRACT_WITH_BORROW,
        NAL_OP_IMM_ADD_SET_CARRY,
        NAL_OP_IMM_SUBTRACT,
        NAL_OP_IMM_ADD_KEEP_CARRY,
        NAL_OP_IMM_CONJUNCTION,
        NAL_OP_IMM_EXCL_DISJUNCTION,
        NAL_OP_IMM_DISJUNCTION
    } nal_op_t;

    // operand source for memory forms
    typedef enum logic [1:0] {
        NAL_SRC_DIRECT,
        NAL_SRC_INDEXED,
        NAL_SRC_INDEXED_INC
    } nal_src_t;

    typedef enum logic [1:0] {
        NAL_ST_IDLE,
        NAL_ST_READ,
        NAL_ST_EXEC
    } nal_state_t;
endpackage

/* File: design/nal_nibble_ram.sv */
// data memory of nibbles, one write and one registered read port
`include "nal_regs.svh"
module nal_nibble_ram #(
    parameter int ADDR_W = `NAL_ADDR_W,
    parameter int DATA_W = `NAL_NIB_W
) (
    input  wire logic              ref_clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data_q
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no reset: contents are undefined until software writes them
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule

/* File: design/nal_nibble_unit.sv */
// combinational four-bit adder and logic unit
`include "nal_regs.svh"
module nal_nibble_unit
    import nal_pkg::*;
#(
    parameter int W = `NAL_NIB_W
) (
    input  nal_pkg::nal_op_t  op,
    input  wire logic [W-1:0] opa,
    input  wire logic [W-1:0] opb,
    input  wire logic         carry_in,
    output logic      [W-1:0] result,
    output logic              carry_out,
    output logic              carry_upd
);
    logic [W:0] sum;

    // one adder serves every arithmetic form; subtraction inverts opb
    function automatic logic [W:0] add3(input logic [W-1:0] a,
                                        input logic [W-1:0] b,
                                        input logic         c);
        add3 = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, c};
    endfunction

    always_comb begin
        sum       = '0;
        result    = '0;
        carry_upd = 1'b0;
        case (op)
            NAL_OP_ADD_KEEP_CARRY,
            NAL_OP_IMM_ADD_KEEP_CARRY: begin
                sum    = add3(opa, opb, 1'b0);
                result = sum[W-1:0];
            end
            NAL_OP_IMM_ADD_WITH_CARRY: begin
                sum       = add3(opa, opb, carry_in);
                result    = sum[W-1:0];
                carry_upd = 1'b1;
            end
            NAL_OP_IMM_SUBTRACT_WITH_BORROW: begin
                sum       = add3(opa, ~opb, carry_in);
                result    = sum[W-1:0];
                carry_upd = 1'b1;
            end
            NAL_OP_IMM_ADD_SET_CARRY: begin
                sum       = add3(opa, opb, 1'b0);
                result    = sum[W-1:0];
                carry_upd = 1'b1;
            end
            NAL_OP_IMM_SUBTRACT: begin
                sum       = add3(opa, ~opb, 1'b1);
                result    = sum[W-1:0];
                carry_upd = 1'b1;
            end
            NAL_OP_CONJUNCTION,
            NAL_OP_IMM_CONJUNCTION:      result = opa & opb;
            NAL_OP_EXCL_DISJUNCTION,
            NAL_OP_IMM_EXCL_DISJUNCTION: result = opa ^ opb;
            NAL_OP_DISJUNCTION,
            NAL_OP_IMM_DISJUNCTION:      result = opa | opb;
            default:                     result = '0;
        endcase
    end

    // truncated to four bits; carry is the bit-three carry out
    assign carry_out = sum[W];
endmodule

/* File: design/nal_alu_datapath.sv */
// nibble arithmetic and logic datapath with its own data memory
//
// What this block does
// - add-keep-carry adds direct memory to result; write-back stores both.
// - every add-keep-carry form leaves the carry flag untouched.
// - post-increment forms add one to the index pointer after the operation.
// - indexed forms address memory through the index pointer.
// - conjunction ANDs memory with result; write-back too.
// - exclusive disjunction XORs memory with result; write-back too.
// - disjunction ORs memory with result; write-back too.
// - indexed write-back stores to result and memory at the index pointer.
// - immediate add-with-carry: register + immediate + carry; carry updated.
// - immediate write-back forms also store the working register.
// - immediate subtract-with-borrow: register + ~immediate + carry.
// - immediate add-set-carry: register + immediate, no carry in.
// - immediate subtract: register + ~immediate + 1; carry updated.
// - immediate conjunction ANDs working register with immediate.
// - immediate exclusive disjunction XORs register with immediate.
// - immediate disjunction ORs working register with immediate.
`include "nal_regs.svh"
module nal_alu_datapath
    import nal_pkg::*;
#(
    parameter int ADDR_W = `NAL_ADDR_W,
    parameter int NIB_W  = `NAL_NIB_W,
    parameter int WREG_W = `NAL_WREG_W
) (
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    input  wire logic               op_valid,
    output logic                    op_ready,
    input  nal_pkg::nal_op_t        op_code,
    input  nal_pkg::nal_src_t       op_src,
    input  wire logic               op_write_back,
    input  wire logic [ADDR_W-1:0]  op_addr,
    input  wire logic [WREG_W-1:0]  op_wreg,
    input  wire logic [NIB_W-1:0]   op_imm,
    input  wire logic               ptr_load,
    input  wire logic [ADDR_W-1:0]  ptr_value,
    input  wire logic               mem_ext_we,
    input  wire logic [ADDR_W-1:0]  mem_ext_addr,
    input  wire logic [NIB_W-1:0]   mem_ext_data,
    output logic                    op_done,
    output logic [NIB_W-1:0]        result_nibble_register,
    output logic                    carry_flag,
    output logic [ADDR_W-1:0]       index_pointer,
    output logic [NIB_W-1:0]        mem_rd_data
);
    import nal_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        nal_state_t        st;
        nal_op_t           op;
        nal_src_t          src;
        logic              wb;
        logic [ADDR_W-1:0] addr;
        logic [NIB_W-1:0]  imm;
        logic [NIB_W-1:0]  acc;
        logic              carry;
        logic [ADDR_W-1:0] ptr;
        logic              done;
    } nal_state_s_t;

    nal_state_s_t s_q;
    nal_state_s_t s_d;

    logic              is_imm;
    logic [ADDR_W-1:0] eff_addr;
    logic [NIB_W-1:0]  mem_q;
    logic [NIB_W-1:0]  opa;
    logic [NIB_W-1:0]  opb;
    logic [NIB_W-1:0]  alu_res;
    logic              alu_cout;
    logic              alu_cupd;
    logic              ram_we;
    logic [ADDR_W-1:0] ram_waddr;
    logic [NIB_W-1:0]  ram_wdata;
    logic [ADDR_W-1:0] ram_raddr;

    // immediate forms read a working register, which lives in memory
    function automatic logic op_is_imm(input nal_op_t o);
        case (o)
            NAL_OP_IMM_ADD_WITH_CARRY,
            NAL_OP_IMM_SUBTRACT_WITH_BORROW,
            NAL_OP_IMM_ADD_SET_CARRY,
            NAL_OP_IMM_SUBTRACT,
            NAL_OP_IMM_ADD_KEEP_CARRY,
            NAL_OP_IMM_CONJUNCTION,
            NAL_OP_IMM_EXCL_DISJUNCTION,
            NAL_OP_IMM_DISJUNCTION: op_is_imm = 1'b1;
            default:                op_is_imm = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // operand addressing
    // ------------------------------------------------------------
    assign is_imm = op_is_imm(s_q.op);
    always_comb begin
        if (is_imm) begin
            eff_addr = ADDR_W'(`NAL_WREG_BASE) | s_q.addr;
        end else if (s_q.src == NAL_SRC_DIRECT) begin
            eff_addr = s_q.addr;
        end else begin
            eff_addr = s_q.ptr;
        end
    end

    assign ram_raddr = (s_q.st == NAL_ST_IDLE) ? mem_ext_addr : eff_addr;

    // ------------------------------------------------------------
    // arithmetic and logic
    // ------------------------------------------------------------
    // memory forms pair the operand with the accumulator
    assign opa = mem_q;
    assign opb = is_imm ? s_q.imm : s_q.acc;

    nal_nibble_unit #(
        .W (NIB_W)
    ) u_unit (
        .op        (s_q.op),
        .opa       (opa),
        .opb       (opb),
        .carry_in  (s_q.carry),
        .result    (alu_res),
        .carry_out (alu_cout),
        .carry_upd (alu_cupd)
    );

    // ------------------------------------------------------------
    // memory
    // ------------------------------------------------------------
    // datapath write-back has priority over the external write port
    always_comb begin
        ram_we    = mem_ext_we;
        ram_waddr = mem_ext_addr;
        ram_wdata = mem_ext_data;
        if (s_q.st == NAL_ST_EXEC && s_q.wb) begin
            ram_we    = 1'b1;
            ram_waddr = eff_addr;
            ram_wdata = alu_res;
        end
    end

    nal_nibble_ram #(
        .ADDR_W (ADDR_W),
        .DATA_W (NIB_W)
    ) u_ram (
        .ref_clk   (ref_clk),
        .wr_en     (ram_we),
        .wr_addr   (ram_waddr),
        .wr_data   (ram_wdata),
        .rd_addr   (ram_raddr),
        .rd_data_q (mem_q)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            NAL_ST_IDLE: begin
                if (ptr_load) begin
                    s_d.ptr = ptr_value;
                end
                if (op_valid && op_code != NAL_OP_NONE) begin
                    s_d.st   = NAL_ST_READ;
                    s_d.op   = op_code;
                    s_d.src  = op_src;
                    s_d.wb   = op_write_back;
                    // the decoder keeps the immediate within four bits
                    s_d.imm  = op_imm;
                    s_d.addr = op_is_imm(op_code)
                             ? ADDR_W'(op_wreg) : op_addr;
                end
            end
            NAL_ST_READ: begin
                // registered memory read needs one cycle
                s_d.st = NAL_ST_EXEC;
            end
            NAL_ST_EXEC: begin
                s_d.st   = NAL_ST_IDLE;
                s_d.done = 1'b1;
                s_d.acc  = alu_res;
                // logic and keep-carry forms never touch the carry
                if (alu_cupd) begin
                    s_d.carry = alu_cout;
                end
                if (!is_imm && s_q.src == NAL_SRC_INDEXED_INC) begin
                    s_d.ptr = s_q.ptr + ADDR_W'(`NAL_PTR_STEP);
                end
            end
            default: s_d.st = NAL_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q       <= '0;
            s_q.st    <= NAL_ST_IDLE;
            s_q.acc   <= `NAL_NIB_ZERO;
            s_q.carry <= `NAL_CARRY_RST;
            s_q.ptr   <= `NAL_PTR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign op_ready               = (s_q.st == NAL_ST_IDLE);
    assign op_done                = s_q.done;
    assign result_nibble_register = s_q.acc;
    assign carry_flag             = s_q.carry;
    assign index_pointer          = s_q.ptr;
    assign mem_rd_data            = mem_q;
endmodule

/* File: tb/nal_alu_assertions.sv */
// concurrent checks on the nibble datapath ports
module nal_alu_assertions #(
    parameter int ADDR_W = 9,
    parameter int NIB_W  = 4
) (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              op_valid,
    input  wire logic              op_ready,
    input  nal_pkg::nal_op_t       op_code,
    input  nal_pkg::nal_src_t      op_src,
    input  wire logic [NIB_W-1:0]  op_imm,
    input  wire logic              op_done,
    input  wire logic [NIB_W-1:0]  result_nibble_register,
    input  wire logic              carry_flag,
    input  wire logic [ADDR_W-1:0] index_pointer
);
    timeunit 1ns;
    timeprecision 1ps;
    import nal_pkg::*;
    // ---------------------------
    // operation classes
    // ---------------------------
    logic take, mop, inc, keep;
    assign take = op_valid && op_ready && op_code != NAL_OP_NONE;
    assign mop = op_code inside {NAL_OP_ADD_KEEP_CARRY, NAL_OP_CONJUNCTION,
        NAL_OP_EXCL_DISJUNCTION, NAL_OP_DISJUNCTION};
    // source field is meaningless for immediate forms, hence mop
    assign inc = mop && op_src == NAL_SRC_INDEXED_INC;
    assign keep = mop || op_code inside {NAL_OP_IMM_ADD_KEEP_CARRY,
        NAL_OP_IMM_CONJUNCTION, NAL_OP_IMM_EXCL_DISJUNCTION,
        NAL_OP_IMM_DISJUNCTION};
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    a_done_timing: assert property (take |-> ##1 !op_done [*2] ##1 op_done)
        else $error("completion pulse off its third cycle");
    a_busy_window: assert property (take |=> !op_ready [*2] ##1 op_ready)
        else $error("ready not low for two cycles");
    a_carry_kept: assert property (
        take && keep |=> $stable(carry_flag) [*3]
    ) else $error("carry changed by a keep-carry form");
    a_ptr_step: assert property (
        take && inc |-> ##3 index_pointer == $past(index_pointer, 3) + 1'b1
    ) else $error("pointer not advanced by one");
    a_ptr_kept: assert property (
        take && !inc |=> $stable(index_pointer) [*3]
    ) else $error("pointer moved without post-increment");
    a_acc_on_done: assert property (
        $changed(result_nibble_register) |-> op_done
    ) else $error("result changed outside completion");
    a_and_subset: assert property (
        take && op_code == NAL_OP_CONJUNCTION |-> ##3
        (result_nibble_register & ~$past(result_nibble_register, 3)) == '0
    ) else $error("conjunction set a clear bit");
    a_imm_or_super: assert property (
        take && op_code == NAL_OP_IMM_DISJUNCTION |-> ##3
        (~result_nibble_register & $past(op_imm, 3)) == '0
    ) else $error("immediate bit missing after disjunction");
    c_post_inc: cover property (take && inc);
    c_borrow: cover property (
        take && op_code == NAL_OP_IMM_SUBTRACT_WITH_BORROW);
    c_done_carry: cover property (op_done && carry_flag);
endmodule

bind nal_alu_datapath nal_alu_assertions #(.ADDR_W(ADDR_W), .NIB_W(NIB_W))
    u_chk (.ref_clk, .arst_n, .op_valid, .op_ready, .op_code, .op_src,
    .op_imm, .op_done, .result_nibble_register, .carry_flag, .index_pointer);

/* File: tb/nal_dec_model.sv */
// decoder model: presents one operation and waits for its completion
module nal_dec_model (
    input  wire logic         ref_clk,
    input  wire logic         op_ready,
    input  wire logic         op_done,
    output logic              op_valid,
    output nal_pkg::nal_op_t  op_code,
    output nal_pkg::nal_src_t op_src,
    output logic              op_write_back,
    output logic [8:0]        op_addr,
    output logic [3:0]        op_wreg,
    output logic [3:0]        op_imm
);
    timeunit 1ns;
    timeprecision 1ps;
    import nal_pkg::*;
    // ---------------------------
    // request handshake
    // ---------------------------
    initial begin
        {op_valid, op_write_back, op_addr, op_wreg, op_imm} = '0;
        op_code = NAL_OP_NONE;
        op_src = NAL_SRC_DIRECT;
    end
    // address and immediate fields are scrambled once taken so a late sampler sees garbage
    task automatic issue(input nal_op_t o, input nal_src_t s,
        input logic w, input logic [8:0] a, input logic [3:0] d);
        op_code = o;
        op_src = s;
        op_write_back = w;
        op_addr = a;
        op_wreg = a[3:0];
        op_imm = d;
        op_valid = 1'b1;
        for (int n = 0; n < 8 && !op_ready; n++) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        op_valid = 1'b0;
        {op_addr, op_imm} = ~{op_addr, op_imm};
        for (int n = 0; n < 8 && !op_done; n++) @(posedge ref_clk) #1;
    endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the nibble datapath
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import nal_pkg::*;
    typedef struct {
        nal_op_t    op;
        nal_src_t   src;
        logic       wb;
        logic [8:0] a;
        logic [3:0] d;
        logic [4:0] r;
    } nal_row_t;
    localparam nal_src_t SD = NAL_SRC_DIRECT;
    localparam nal_src_t SX = NAL_SRC_INDEXED_INC;
    logic        ref_clk = 1'b0;
    logic        arst_n, op_valid, op_ready, op_write_back, op_done, cf;
    logic        ptr_load, mem_ext_we;
    nal_op_t     op_code;
    nal_src_t    op_src;
    logic [8:0]  op_addr, ptr_value, mem_ext_addr, ptr;
    logic [3:0]  op_wreg, op_imm, mem_ext_data, acc, mem_rd_data;
    logic [12:0] pre [6];
    int          mismatches = 0;
    int          checks_done = 0;
    nal_row_t    rows [14];
    // ---------------------------
    // clock, partner and design
    // ---------------------------
    always #2.5 ref_clk = ~ref_clk;
    nal_dec_model u_dec (.ref_clk, .op_ready, .op_done, .op_valid, .op_code,
        .op_src, .op_write_back, .op_addr, .op_wreg, .op_imm);
    nal_alu_datapath DUT (.ref_clk, .arst_n, .op_valid, .op_ready, .op_code,
        .op_src, .op_write_back, .op_addr, .op_wreg, .op_imm, .ptr_load,
        .ptr_value, .mem_ext_we, .mem_ext_addr, .mem_ext_data, .op_done,
        .result_nibble_register(acc), .carry_flag(cf), .index_pointer(ptr),
        .mem_rd_data);
    task automatic rd(input logic [8:0] a, input logic [3:0] e);
        mem_ext_addr = a;
        @(posedge ref_clk) #1;
        `CHK(mem_rd_data, e)
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // about 16 operations of three cycles need well under 1 us
    initial begin
        #5us;
        mismatches++;
        end_sim();
    end
    initial begin
        {arst_n, ptr_load, mem_ext_we, ptr_value, mem_ext_addr} = '0;
        mem_ext_data = 4'h0;
        pre = '{13'h0019, 13'h0026, 13'h003f, 13'h020a, 13'h0215, 13'h1ffc};
        // r is the result nibble above the carry flag
        rows = '{
        '{NAL_OP_IMM_ADD_SET_CARRY, SD, 1'b0, 9'h001, 4'h7, 5'h01},
        '{NAL_OP_IMM_ADD_WITH_CARRY, SD, 1'b0, 9'h002, 4'h8, 5'h1e},
        '{NAL_OP_IMM_SUBTRACT, SD, 1'b0, 9'h001, 4'ha, 5'h1e},
        '{NAL_OP_IMM_SUBTRACT_WITH_BORROW, SD, 1'b0, 9'h003, 4'h2, 5'h19},
        '{NAL_OP_IMM_ADD_KEEP_CARRY, SD, 1'b0, 9'h003, 4'h3, 5'h05},
        '{NAL_OP_IMM_CONJUNCTION, SD, 1'b0, 9'h001, 4'hc, 5'h11},
        '{NAL_OP_IMM_EXCL_DISJUNCTION, SD, 1'b0, 9'h002, 4'h3, 5'h0b},
        '{NAL_OP_IMM_ADD_SET_CARRY, SD, 1'b1, 9'h001, 4'h1, 5'h14},
        '{NAL_OP_IMM_DISJUNCTION, SD, 1'b0, 9'h002, 4'h8, 5'h1c},
        '{NAL_OP_CONJUNCTION, SD, 1'b0, 9'h002, 4'h0, 5'h0c},
        '{NAL_OP_ADD_KEEP_CARRY, SD, 1'b1, 9'h003, 4'h0, 5'h0a},
        '{NAL_OP_DISJUNCTION, NAL_SRC_INDEXED, 1'b0, 9'h000, 4'h0, 5'h1e},
        '{NAL_OP_EXCL_DISJUNCTION, SX, 1'b1, 9'h000, 4'h0, 5'h0a},
        '{NAL_OP_ADD_KEEP_CARRY, SX, 1'b0, 9'h000, 4'h0, 5'h14}};
        repeat (4) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        `CHK({acc, cf, ptr, op_ready, op_done}, 16'h0002)
        $display("reset test done");
        foreach (pre[i]) begin
            {mem_ext_we, mem_ext_addr, mem_ext_data} = {1'b1, pre[i]};
            @(posedge ref_clk) #1;
        end
        {mem_ext_we, ptr_load, ptr_value} = {2'b01, 9'h020};
        @(posedge ref_clk) #1;
        ptr_load = 1'b0;
        foreach (rows[i]) begin
            u_dec.issue(rows[i].op, rows[i].src, rows[i].wb, rows[i].a,
                rows[i].d);
            `CHK(acc, rows[i].r[4:1])
            `CHK(cf, rows[i].r[0])
        end
        `CHK(ptr, 9'h022)
        $display("table test done");
        rd(9'h001, 4'ha);
        rd(9'h003, 4'h5);
        rd(9'h020, 4'h5);
        rd(9'h002, 4'h6);
        $display("memory test done");
        {ptr_load, ptr_value} = {1'b1, 9'h1ff};
        @(posedge ref_clk) #1;
        ptr_load = 1'b0;
        u_dec.issue(NAL_OP_EXCL_DISJUNCTION, SX, 1'b0, 9'h000, 4'h0);
        `CHK(acc, 4'h6)
        `CHK(ptr, 9'h000)
        $display("pointer wrap test done");
        arst_n = 1'b0;
        @(posedge ref_clk) #1;
        `CHK({acc, cf, ptr, op_ready, op_done}, 16'h0002)
        arst_n = 1'b1;
        // memory survives reset: working register 2 still holds 6
        u_dec.issue(NAL_OP_IMM_ADD_SET_CARRY, SD, 1'b0, 9'h002, 4'hc);
        `CHK(acc, 4'h2)
        `CHK(cf, 1'b1)
        $display("mid-run reset test done");
        end_sim();
    end
endmodule
